/* File: src/atacd_consts.svh */
`ifndef ATACD_CONSTS_SVH
`define ATACD_CONSTS_SVH
`define ATACD_OP_CHK_PWR_A 8'he5
`define ATACD_OP_CHK_PWR_B 8'h98
`define ATACD_OP_DIAG 8'h90
`define ATACD_OP_ERASE 8'hc0
`define ATACD_OP_FLUSH 8'he7
`define ATACD_OP_FORMAT 8'h50
`define ATACD_OP_IDENT 8'hec
`define ATACD_OP_IDLE_A 8'he3
`define ATACD_OP_IDLE_B 8'h97
`define ATACD_OP_IDLEI_A 8'he1
`define ATACD_OP_IDLEI_B 8'h95
`define ATACD_OP_INITP 8'h91
`define ATACD_OP_KEYMGT 8'hb9
`define ATACD_OP_NOP 8'h00
`define ATACD_OP_RDBUF 8'he4
`define ATACD_OP_RDDMA 8'hc8
`define ATACD_OP_RDLONG_A 8'h22
`define ATACD_OP_RDLONG_B 8'h23
`define ATACD_OP_RDMUL 8'hc4
`define ATACD_OP_RD_A 8'h20
`define ATACD_OP_RD_B 8'h21
`define ATACD_OP_RDVER_A 8'h40
`define ATACD_OP_RDVER_B 8'h41
`define ATACD_OP_RECAL_HI 4'h1
`define ATACD_OP_REQSENSE 8'h03
`define ATACD_OP_SEC_SETPW 8'hf1
`define ATACD_OP_SEC_UNLOCK 8'hf2
`define ATACD_OP_SEC_ERPREP 8'hf3
`define ATACD_OP_SEC_ERUNIT 8'hf4
`define ATACD_OP_SEC_FREEZE 8'hf5
`define ATACD_OP_SEC_DISPW 8'hf6
`define ATACD_OP_SEEK_HI 4'h7
`define ATACD_OP_SETFEAT 8'hef
`define ATACD_OP_SETMUL 8'hc6
`define ATACD_OP_SLEEP_A 8'he6
`define ATACD_OP_SLEEP_B 8'h99
`define ATACD_OP_STBY_A 8'he2
`define ATACD_OP_STBY_B 8'h96
`define ATACD_OP_STBYI_A 8'he0
`define ATACD_OP_STBYI_B 8'h94
`define ATACD_OP_XLATE 8'h87
`define ATACD_OP_WRBUF 8'he8
`define ATACD_OP_WRDMA 8'hca
`define ATACD_OP_WRLONG_A 8'h32
`define ATACD_OP_WRLONG_B 8'h33
`define ATACD_OP_WRMUL 8'hc5
`define ATACD_OP_WRMUL_NE 8'hcd
`define ATACD_OP_WR_A 8'h30
`define ATACD_OP_WR_B 8'h31
`define ATACD_OP_WR_NE 8'h38
`define ATACD_OP_WRVER 8'h3c
`define ATACD_SC_ASLEEP 8'h00
`define ATACD_SC_IDLE 8'hff
`define ATACD_STAT_SKIP 8'h50
`define ATACD_STAT_DONE 8'h50
`define ATACD_STAT_ABORT 8'h51
`define ATACD_ERR_ABORT 8'h04
`define ATACD_DIAG_OK 8'h01
`define ATACD_DIAG_SLAVE 8'h80
`define ATACD_DRV_BIT 4
`define ATACD_LBA_BIT 6
`define ATACD_BUSY_CYCLES 4
`endif

/* File: src/atacd_pkg.sv */
`default_nettype none
package atacd_pkg;
   typedef enum logic [1:0] {
      ATACD_PWR_IDLE,
      ATACD_PWR_SLEEP,
      ATACD_PWR_TO_SLEEP,
      ATACD_PWR_WAKING
   } atacd_pwr_e;
   typedef enum logic [3:0] {
      ATACD_CMD_NONE,
      ATACD_CMD_CHK_PWR,
      ATACD_CMD_DIAG,
      ATACD_CMD_MEDIA,
      ATACD_CMD_IDLE,
      ATACD_CMD_STANDBY,
      ATACD_CMD_SLEEP,
      ATACD_CMD_OTHER,
      ATACD_CMD_ABORT,
      ATACD_CMD_SKIP
   } atacd_cmd_e;
   // which task-file registers the command takes
   typedef struct packed {
      logic feat;
      logic count;
      logic secnum;
      logic cyl;
      logic head;
      logic lba_ok;
   } atacd_use_s;
   typedef struct packed {
      atacd_cmd_e cmd;
      atacd_use_s use_map;
   } atacd_dec_s;
   // parameters handed to the media engine
   typedef struct packed {
      logic [8:0]  count;
      logic [27:0] addr;
      logic        lba_mode;
      logic [3:0]  head;
      logic        drive;
      logic [7:0]  feature;
   } atacd_task_s;
endpackage : atacd_pkg
`default_nettype wire

/* File: src/atacd_opcode_rom.sv */
`default_nettype none
`include "atacd_consts.svh"
module atacd_opcode_rom
   import atacd_pkg::*;
(
   input  wire logic       sys_clk_in,
   input  wire logic       reset_n_in,
   input  wire logic [7:0] opcode_in,
   input  wire logic       skip_in,
   output atacd_dec_s      dec_out
);
   // bits: feat, count, secnum, cyl, head, lba_ok
   function automatic atacd_use_s u(input logic [5:0] m);
      u = atacd_use_s'(m);
   endfunction : u
   atacd_dec_s dec_next;
   always_comb begin
      dec_next = '{cmd: ATACD_CMD_OTHER, use_map: u(6'b000010)};
      case (opcode_in)
         `ATACD_OP_CHK_PWR_A, `ATACD_OP_CHK_PWR_B: dec_next.cmd = ATACD_CMD_CHK_PWR;
         `ATACD_OP_DIAG: dec_next.cmd = ATACD_CMD_DIAG;
         `ATACD_OP_IDLE_A, `ATACD_OP_IDLE_B:
            dec_next = '{cmd: ATACD_CMD_IDLE, use_map: u(6'b010010)};
         `ATACD_OP_IDLEI_A, `ATACD_OP_IDLEI_B: dec_next.cmd = ATACD_CMD_IDLE;
         `ATACD_OP_STBY_A, `ATACD_OP_STBY_B,
         `ATACD_OP_STBYI_A, `ATACD_OP_STBYI_B: dec_next.cmd = ATACD_CMD_STANDBY;
         `ATACD_OP_SLEEP_A, `ATACD_OP_SLEEP_B: dec_next.cmd = ATACD_CMD_SLEEP;
         `ATACD_OP_ERASE, `ATACD_OP_RDDMA, `ATACD_OP_RDMUL, `ATACD_OP_RD_A, `ATACD_OP_RD_B,
         `ATACD_OP_RDVER_A, `ATACD_OP_RDVER_B, `ATACD_OP_XLATE, `ATACD_OP_WRDMA,
         `ATACD_OP_WRMUL, `ATACD_OP_WRMUL_NE, `ATACD_OP_WR_A, `ATACD_OP_WR_B,
         `ATACD_OP_WR_NE, `ATACD_OP_WRVER:
            dec_next = '{cmd: ATACD_CMD_MEDIA, use_map: u(6'b011111)};
         `ATACD_OP_FORMAT:
            dec_next = '{cmd: ATACD_CMD_MEDIA, use_map: u(6'b010111)};
         `ATACD_OP_INITP, `ATACD_OP_SETMUL: dec_next.use_map = u(6'b010010);
         `ATACD_OP_SETFEAT: dec_next.use_map = u(6'b100010);
         `ATACD_OP_FLUSH, `ATACD_OP_KEYMGT, `ATACD_OP_NOP, `ATACD_OP_RDLONG_A,
         `ATACD_OP_RDLONG_B, `ATACD_OP_WRLONG_A, `ATACD_OP_WRLONG_B:
            dec_next.cmd = ATACD_CMD_ABORT;
         default: begin
            if (opcode_in[7:4] == `ATACD_OP_SEEK_HI)
               dec_next = '{cmd: ATACD_CMD_MEDIA, use_map: u(6'b001111)};
            else if (opcode_in[7:4] != `ATACD_OP_RECAL_HI && opcode_in != `ATACD_OP_IDENT
                     && opcode_in != `ATACD_OP_RDBUF && opcode_in != `ATACD_OP_WRBUF
                     && opcode_in != `ATACD_OP_REQSENSE && opcode_in[7:4] != 4'hf)
               dec_next.cmd = ATACD_CMD_ABORT;
         end
      endcase
      if (skip_in)
         dec_next.cmd = ATACD_CMD_SKIP;
   end
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in)
         dec_out <= '0;
      else
         dec_out <= dec_next;
   end
endmodule : atacd_opcode_rom
`default_nettype wire

/* File: src/atacd_decoder.sv */
// Function
// - power query while asleep, entering or waking loads count 00h, interrupts
// - power query while idle loads count ffh, then interrupts
// - card-interface modes: diagnostic runs only on the selected card
// - disk-interface mode: diagnostic ignores drive bit, master reports both
// - diagnostic ends with a result code in the error register
// - sector count zero means 256 sectors
// - head number is the 4-bit drive/head field, 0 to 15
// - skip-flagged command not executed, status 50h returned
// - opcode 38h decodes as write without erase, block addressing allowed
// - opcode cdh decodes as multiple write without erase, block addressing
// - head used for every command: each use map, the default included, sets the head bit
// - block addressing honoured only for commands that support it
// - key management opcode b9 not implemented
// - unimplemented commands end with command aborted
// - primary status read clears interrupt, alternate status read does not
// - drive bit 4 selects card; only selected card executes, except diagnostic in disk-interface mode
`default_nettype none
`include "atacd_consts.svh"
module atacd_decoder
   import atacd_pkg::*;
#(
   parameter int BUSY_CYCLES = `ATACD_BUSY_CYCLES
) (
   input  wire logic        sys_clk_in,
   input  wire logic        reset_n_in,
   input  wire logic        cmd_write_in,
   input  wire logic [7:0]  cmd_opcode_in,
   input  wire logic [7:0]  feature_reg_in,
   input  wire logic [7:0]  sector_count_reg_in,
   input  wire logic [7:0]  sector_number_reg_in,
   input  wire logic [15:0] cylinder_regs_in,
   input  wire logic [7:0]  drive_head_reg_in,
   input  wire logic        card_id_in,
   input  wire logic        disk_interface_mode_in,
   input  wire logic        is_master_in,
   input  wire logic        slave_fault_in,
   input  wire logic [3:0]  slave_code_in,
   input  wire logic        skip_in,
   input  wire atacd_pwr_e  pwr_state_in,
   input  wire logic [7:0]  diag_result_in,
   input  wire logic        status_read_in,
   input  wire logic        alt_status_read_in,
   output logic             busy_flag_out,
   output logic             sc_load_out,
   output logic [7:0]       sc_value_out,
   output logic             err_load_out,
   output logic [7:0]       err_value_out,
   output logic [7:0]       status_out,
   output logic             intrq_out,
   output logic             media_start_out,
   output atacd_task_s      task_out,
   output logic             pwr_req_out,
   output atacd_cmd_e       pwr_cmd_out
);
   typedef enum {ATACD_ST_IDLE, ATACD_ST_DECODE, ATACD_ST_EXEC, ATACD_ST_HOLD} atacd_st_e;
   // hold counter is only 8 bits wide
   if (BUSY_CYCLES < 1 || BUSY_CYCLES > 255) begin : g_busy_range
      $error("busy cycles out of range");
   end
   atacd_dec_s dec;
   atacd_st_e  st_reg, st_next;
   logic [7:0] hold_reg;
   logic       intrq_reg;
   logic [7:0] status_reg;
   logic [7:0] dh_reg;
   atacd_opcode_rom u_rom (
      .sys_clk_in (sys_clk_in),
      .reset_n_in (reset_n_in),
      .opcode_in  (cmd_opcode_in),
      .skip_in    (skip_in),
      .dec_out    (dec)
   );
   wire selected     = dh_reg[`ATACD_DRV_BIT] == card_id_in;
   wire diag_runs    = disk_interface_mode_in || selected;
   wire runs         = (dec.cmd == ATACD_CMD_DIAG) ? diag_runs : selected;
   wire diag_answers = disk_interface_mode_in ? is_master_in : 1'b1;
   wire [7:0] diag_code = (disk_interface_mode_in && slave_fault_in)
                          ? (`ATACD_DIAG_SLAVE | {4'h0, slave_code_in}) : diag_result_in;
   // sleep states zero, idle all ones
   wire [7:0] pwr_count  = (pwr_state_in == ATACD_PWR_IDLE) ? `ATACD_SC_IDLE
                          : `ATACD_SC_ASLEEP;
   wire lba_on = dec.use_map.lba_ok && drive_head_reg_in[`ATACD_LBA_BIT];
   wire [3:0] head_f = dec.use_map.head ? drive_head_reg_in[3:0] : 4'h0;
   wire [8:0] count9 = (sector_count_reg_in == 8'h00) ? 9'h100 : {1'b0, sector_count_reg_in};
   wire exec = (st_reg == ATACD_ST_EXEC);
   always_comb begin
      st_next = st_reg;
      case (st_reg)
         ATACD_ST_IDLE:   if (cmd_write_in) st_next = ATACD_ST_DECODE;
         ATACD_ST_DECODE: st_next = ATACD_ST_EXEC;
         ATACD_ST_EXEC:   st_next = ATACD_ST_HOLD;
         ATACD_ST_HOLD:   if (hold_reg == 8'h00) st_next = ATACD_ST_IDLE;
         default:         st_next = ATACD_ST_IDLE;
      endcase
   end
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         st_reg   <= ATACD_ST_IDLE;
         hold_reg <= 8'h00;
         dh_reg   <= 8'h00;
      end else begin
         st_reg   <= st_next;
         if (cmd_write_in && st_reg == ATACD_ST_IDLE)
            dh_reg <= drive_head_reg_in;
         hold_reg <= exec ? 8'(BUSY_CYCLES - 1) : (hold_reg != 8'h00 ? hold_reg - 8'h01 : 8'h00);
      end
   end
   // busy from command write to completion
   assign busy_flag_out = (st_reg != ATACD_ST_IDLE) || cmd_write_in;
   wire fire = exec && runs;
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sc_load_out     <= 1'b0;
         sc_value_out    <= 8'h00;
         err_load_out    <= 1'b0;
         err_value_out   <= 8'h00;
         status_reg      <= 8'h00;
         media_start_out <= 1'b0;
         pwr_req_out     <= 1'b0;
         pwr_cmd_out     <= ATACD_CMD_NONE;
         task_out        <= '0;
      end else begin
         sc_load_out     <= fire && dec.cmd == ATACD_CMD_CHK_PWR;
         sc_value_out    <= pwr_count;
         err_load_out    <= fire && ((dec.cmd == ATACD_CMD_DIAG && diag_answers)
                                     || dec.cmd == ATACD_CMD_ABORT);
         err_value_out   <= (dec.cmd == ATACD_CMD_ABORT) ? `ATACD_ERR_ABORT : diag_code;
         media_start_out <= fire && dec.cmd == ATACD_CMD_MEDIA;
         pwr_req_out     <= fire && (dec.cmd == ATACD_CMD_IDLE
                                     || dec.cmd == ATACD_CMD_STANDBY
                                     || dec.cmd == ATACD_CMD_SLEEP);
         pwr_cmd_out     <= dec.cmd;
         if (fire) begin
            status_reg <= (dec.cmd == ATACD_CMD_SKIP) ? `ATACD_STAT_SKIP
                        : (dec.cmd == ATACD_CMD_ABORT) ? `ATACD_STAT_ABORT : `ATACD_STAT_DONE;
            task_out <= '{count: dec.use_map.count ? count9 : 9'h000,
                          addr: {drive_head_reg_in[3:0], cylinder_regs_in, sector_number_reg_in},
                          lba_mode: lba_on, head: head_f,
                          drive: drive_head_reg_in[`ATACD_DRV_BIT],
                          feature: dec.use_map.feat ? feature_reg_in : 8'h00};
         end
      end
   end
   assign status_out = status_reg;
   // interrupt cleared by primary status read or by command write
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in)
         intrq_reg <= 1'b0;
      else if (st_reg == ATACD_ST_HOLD && hold_reg == 8'h00 && runs
               && dec.cmd != ATACD_CMD_MEDIA)
         intrq_reg <= 1'b1;
      else if (status_read_in || cmd_write_in)
         intrq_reg <= 1'b0;
   end
   assign intrq_out = intrq_reg;
   busy_on_write_a : assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      cmd_write_in && st_reg == ATACD_ST_IDLE |=> busy_flag_out)
      else $error("busy not held after command write");
   pwr_query_a : assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      sc_load_out |-> (sc_value_out == 8'hff) == ($past(pwr_state_in) == ATACD_PWR_IDLE))
      else $error("power query count wrong");
   idle_count_a : assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      sc_load_out && $past(pwr_state_in) == ATACD_PWR_IDLE |-> sc_value_out == 8'hff)
      else $error("idle power query count wrong");
   skip_status_a : assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      $past(fire) && $past(dec.cmd) == ATACD_CMD_SKIP |-> status_out == 8'h50)
      else $error("skip status not 50h");
   count_256_a : assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      $past(fire) && $past(dec.use_map.count) && $past(sector_count_reg_in) == 8'h00
      |-> task_out.count == 9'h100)
      else $error("zero count not 256");
   count_plain_a : assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      fire && dec.use_map.count && sector_count_reg_in != 8'h00
      |=> task_out.count == {1'b0, $past(sector_count_reg_in)})
      else $error("nonzero count changed");
   alt_keeps_a : assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      intrq_out && alt_status_read_in && !status_read_in && !cmd_write_in
      |=> intrq_out)
      else $error("alternate read cleared interrupt");
   status_clear_a : assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      status_read_in && st_reg == ATACD_ST_IDLE |=> !intrq_out)
      else $error("status read left interrupt");
   diag_select_a : assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      exec && dec.cmd == ATACD_CMD_DIAG && !disk_interface_mode_in && !selected
      |=> !err_load_out)
      else $error("diagnostic ran on unselected card");
   diag_slave_a : assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      exec && dec.cmd == ATACD_CMD_DIAG && disk_interface_mode_in && !is_master_in
      |=> !err_load_out)
      else $error("slave reported diagnostic");
   slave_code_a : assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      exec && dec.cmd == ATACD_CMD_DIAG && disk_interface_mode_in && slave_fault_in
      |=> err_value_out == (`ATACD_DIAG_SLAVE | {4'h0, $past(slave_code_in)}))
      else $error("slave fault code wrong");
   quiet_unsel_a : assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      exec && dec.cmd != ATACD_CMD_DIAG && !selected
      |=> !(sc_load_out || err_load_out || media_start_out || pwr_req_out))
      else $error("unselected card executed");
   head_field_a : assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      fire && dec.cmd == ATACD_CMD_MEDIA |=> task_out.head == $past(drive_head_reg_in[3:0]))
      else $error("head field wrong");
   write_ne_a : assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      fire && cmd_opcode_in == `ATACD_OP_WR_NE && dec.cmd != ATACD_CMD_SKIP
      |=> media_start_out && task_out.lba_mode == $past(drive_head_reg_in[`ATACD_LBA_BIT]))
      else $error("write without erase not started");
   write_mul_ne_a : assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      fire && cmd_opcode_in == `ATACD_OP_WRMUL_NE && dec.cmd != ATACD_CMD_SKIP
      |=> media_start_out && task_out.lba_mode == $past(drive_head_reg_in[`ATACD_LBA_BIT]))
      else $error("multiple write without erase not started");
   abort_keys_a : assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      fire && cmd_opcode_in == `ATACD_OP_KEYMGT && dec.cmd != ATACD_CMD_SKIP
      |=> err_load_out && err_value_out == `ATACD_ERR_ABORT)
      else $error("key management not aborted");
   lba_gate_a : assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      fire && !dec.use_map.lba_ok |=> !task_out.lba_mode)
      else $error("block addressing on unsupported command");
   abort_code_a : assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
      fire && dec.cmd == ATACD_CMD_ABORT |=> err_load_out && status_out[0])
      else $error("abort not reported");
endmodule : atacd_decoder
`default_nettype wire

/* File: dv/atacd_host_model.sv */
`default_nettype none
module atacd_host_model
   import atacd_pkg::*;
(
   input  wire logic        sys_clk_in,
   input  wire logic        busy_flag_in,
   input  wire logic        sc_load_in,
   input  wire logic [7:0]  sc_value_in,
   input  wire logic        err_load_in,
   input  wire logic [7:0]  err_value_in,
   input  wire logic        media_start_in,
   input  wire atacd_task_s task_in,
   input  wire logic        pwr_req_in,
   output logic             cmd_write_out,
   output logic [7:0]       opcode_out,
   output logic [7:0]       feature_out,
   output logic [7:0]       count_out,
   output logic [7:0]       secnum_out,
   output logic [15:0]      cyl_out,
   output logic [7:0]       dh_out,
   output logic             status_read_out,
   output logic             alt_read_out
);
   timeunit 1ns;
   timeprecision 100ps;
   // sc, err, media, pwr pulses seen during the last command
   logic [3:0]  seen_mask;
   logic [7:0]  seen_sc;
   logic [7:0]  seen_err;
   logic        seen_busy;
   atacd_task_s seen_task;
   initial begin
      cmd_write_out   = 1'b0;
      opcode_out      = 8'h00;
      feature_out     = 8'h00;
      count_out       = 8'h00;
      secnum_out      = 8'h00;
      cyl_out         = 16'h0000;
      dh_out          = 8'ha0;
      status_read_out = 1'b0;
      alt_read_out    = 1'b0;
   end
   // security family never issued by this host
   // next command once busy has dropped, or after 300 cycles at most
   task automatic issue(input logic [7:0] op, input logic [7:0] dh, input logic [7:0] sc,
                        input logic [7:0] sn, input logic [15:0] cy);
      int i;
      seen_mask = 4'h0;
      @(posedge sys_clk_in);
      cmd_write_out <= 1'b1;
      opcode_out    <= op;
      dh_out        <= dh;
      count_out     <= sc;
      secnum_out    <= sn;
      cyl_out       <= cy;
      feature_out   <= sc ^ sn;
      @(posedge sys_clk_in);
      cmd_write_out <= 1'b0;
      #1;
      seen_busy = busy_flag_in;
      // task file held until the next command, never released mid-busy
      for (i = 0; i < 300; i++) begin
         @(posedge sys_clk_in);
         #1;
         if (sc_load_in === 1'b1) begin
            seen_mask[0] = 1'b1;
            seen_sc      = sc_value_in;
         end
         if (err_load_in === 1'b1) begin
            seen_mask[1] = 1'b1;
            seen_err     = err_value_in;
         end
         if (media_start_in === 1'b1) begin
            seen_mask[2] = 1'b1;
            seen_task    = task_in;
         end
         if (pwr_req_in === 1'b1) seen_mask[3] = 1'b1;
         if (busy_flag_in === 1'b0) break;
      end
   endtask : issue
   task automatic read_status(input logic alt);
      @(posedge sys_clk_in);
      if (alt) alt_read_out <= 1'b1;
      else status_read_out <= 1'b1;
      @(posedge sys_clk_in);
      alt_read_out    <= 1'b0;
      status_read_out <= 1'b0;
   endtask : read_status
endmodule : atacd_host_model
`default_nettype wire

/* File: dv/tb.sv */
`default_nettype none
module tb
   import atacd_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic        sys_clk_in = 1'b0, reset_n_in = 1'b0;
   logic        cmd_write, status_read, alt_read, busy, sc_load, err_load, media, pwr_req, intrq;
   logic [7:0]  opcode, feature, count, secnum, dh, sc_value, err_value, status;
   logic [15:0] cyl;
   logic        card_id = 1'b0, disk_mode = 1'b0, is_master = 1'b1, slave_fault = 1'b0;
   logic        skip = 1'b0;
   logic [3:0]  slave_code = 4'h0;
   logic [7:0]  diag_result = 8'h01;
   atacd_pwr_e  pwr_state = ATACD_PWR_IDLE;
   atacd_task_s task_v;
   atacd_cmd_e  pwr_cmd;
   int          n_mismatch = 0, samples_checked = 0, cycles = 0, i, s;
   logic [31:0] seed = 32'h5296aff9;
   logic [7:0]  r_sc, r_sn, r_dh;
   logic [15:0] r_cy;
   logic [7:0]  ops[$];
   atacd_cmd_e  kinds[$];
   atacd_decoder #(.BUSY_CYCLES(3)) dut_u (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
      .cmd_write_in(cmd_write), .cmd_opcode_in(opcode), .feature_reg_in(feature),
      .sector_count_reg_in(count), .sector_number_reg_in(secnum), .cylinder_regs_in(cyl),
      .drive_head_reg_in(dh), .card_id_in(card_id), .disk_interface_mode_in(disk_mode),
      .is_master_in(is_master), .slave_fault_in(slave_fault), .slave_code_in(slave_code),
      .skip_in(skip), .pwr_state_in(pwr_state), .diag_result_in(diag_result),
      .status_read_in(status_read), .alt_status_read_in(alt_read), .busy_flag_out(busy),
      .sc_load_out(sc_load), .sc_value_out(sc_value), .err_load_out(err_load),
      .err_value_out(err_value), .status_out(status), .intrq_out(intrq),
      .media_start_out(media), .task_out(task_v), .pwr_req_out(pwr_req),
      .pwr_cmd_out(pwr_cmd));
   atacd_host_model host_u (.sys_clk_in(sys_clk_in), .busy_flag_in(busy), .sc_load_in(sc_load),
      .sc_value_in(sc_value), .err_load_in(err_load), .err_value_in(err_value),
      .media_start_in(media), .task_in(task_v), .pwr_req_in(pwr_req),
      .cmd_write_out(cmd_write), .opcode_out(opcode), .feature_out(feature),
      .count_out(count), .secnum_out(secnum), .cyl_out(cyl), .dh_out(dh),
      .status_read_out(status_read), .alt_read_out(alt_read));
   initial begin
      forever #5 sys_clk_in = ~sys_clk_in;
   end
   // ceiling well above the few hundred cycles the sequence needs
   always @(posedge sys_clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_mismatch = n_mismatch + 1;
         report_and_stop();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
         n_mismatch = n_mismatch + 1;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic report_and_stop();
      $display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop
   function automatic logic [7:0] sel_dh(input logic drv, input logic [7:0] r);
      return {1'b1, r[6], 1'b1, drv, r[3:0]};
   endfunction : sel_dh
   initial begin
      repeat (16) @(posedge sys_clk_in);
      reset_n_in <= 1'b1;
      ops = '{8'he5, 8'h98};
      foreach (ops[k]) begin
         for (s = 0; s < 4; s++) begin
            @(posedge sys_clk_in);
            pwr_state <= atacd_pwr_e'(s);
            host_u.issue(ops[k], 8'ha0, 8'h5a, 8'h00, 16'h0000);
            check(host_u.seen_busy, 1);
            check(busy, 0);
            check(host_u.seen_mask, 4'h1);
            check(host_u.seen_sc, (s == 0) ? 8'hff : 8'h00);
            check(status, 8'h50);
            check(intrq, 1);
            host_u.read_status(1'b1);
            @(posedge sys_clk_in);
            #1;
            check(intrq, 1);
            host_u.read_status(1'b0);
            @(posedge sys_clk_in);
            #1;
            check(intrq, 0);
         end
      end
      ops = '{8'he3, 8'h97, 8'he1, 8'h95, 8'he2, 8'h96, 8'he0, 8'h94, 8'he6, 8'h99};
      kinds = '{ATACD_CMD_IDLE, ATACD_CMD_IDLE, ATACD_CMD_IDLE, ATACD_CMD_IDLE,
                ATACD_CMD_STANDBY, ATACD_CMD_STANDBY, ATACD_CMD_STANDBY, ATACD_CMD_STANDBY,
                ATACD_CMD_SLEEP, ATACD_CMD_SLEEP};
      foreach (ops[k]) begin
         host_u.issue(ops[k], 8'ha0, 8'h10, 8'h00, 16'h0000);
         check(host_u.seen_mask, 4'h8);
         check({28'h0, pwr_cmd}, {28'h0, kinds[k]});
      end
      // diagnostic: card mode selected, card mode other card, disk mode master and slave
      for (i = 0; i < 5; i++) begin
         @(posedge sys_clk_in);
         diag_result <= 8'(i + 1);
         disk_mode   <= (i > 1);
         is_master   <= (i != 4);
         slave_fault <= (i == 3);
         slave_code  <= 4'($random(seed));
         host_u.issue(8'h90, sel_dh(i == 1 || i == 3, 8'h00), 8'h00, 8'h00, 16'h0000);
         check(host_u.seen_mask, (i == 1 || i == 4) ? 4'h0 : 4'h2);
         if (i == 1) check(intrq, 0);
         if (i == 0 || i == 2) check(host_u.seen_err, 8'(i + 1));
         if (i == 3) check(host_u.seen_err, {4'h8, slave_code});
      end
      disk_mode <= 1'b0;
      ops = '{8'h38, 8'hcd, 8'h38, 8'hcd};
      foreach (ops[k]) begin
         r_sc = (k == 0) ? 8'h00 : 8'($random(seed));
         r_sn = 8'($random(seed));
         r_cy = 16'($random(seed));
         r_dh = sel_dh(card_id, 8'($random(seed)));
         host_u.issue(ops[k], r_dh, r_sc, r_sn, r_cy);
         check(host_u.seen_mask, 4'h4);
         check({23'h0, host_u.seen_task.count}, (r_sc == 0) ? 256 : r_sc);
         check({4'h0, host_u.seen_task.addr}, {4'h0, r_dh[3:0], r_cy, r_sn});
         check(host_u.seen_task.head, r_dh[3:0]);
         check(host_u.seen_task.lba_mode, r_dh[6]);
         check(host_u.seen_task.drive, 1'b0);
         check(host_u.seen_task.feature, 8'h00);
      end
      host_u.issue(8'h20, sel_dh(1'b1, 8'h00), 8'h01, 8'h01, 16'h0000);
      check(host_u.seen_mask, 4'h0);
      @(posedge sys_clk_in);
      skip <= 1'b1;
      // an opcode that would abort, so a missed skip shows as 51h
      host_u.issue(8'he7, 8'ha0, 8'h01, 8'h01, 16'h0000);
      check(host_u.seen_mask, 4'h0);
      check(status, 8'h50);
      @(posedge sys_clk_in);
      skip <= 1'b0;
      ops = '{8'he7, 8'hb9};
      foreach (ops[k]) begin
         host_u.issue(ops[k], 8'ha0, 8'h01, 8'h01, 16'h0000);
         check(status, 8'h51);
         check(host_u.seen_mask, 4'h2);
         check(host_u.seen_err, 8'h04);
      end
      report_and_stop();
   end
endmodule : tb
`default_nettype wire
